// >>> include/asbs_map.svh
// Address, reset and arithmetic constants for the status and bank select register
`ifndef ASBS_MAP_SVH
`define ASBS_MAP_SVH

`define ASBS_STATUS_ADDR  7'h03
`define ASBS_BANK1_BASE   8'h80
`define ASBS_STATUS_RESET 8'h18
`define ASBS_NIBBLE_MAX   5'h0F
`define ASBS_ZERO_BYTE    8'h00

`endif

// >>> include/asbs_pkg.sv
// Types shared by the status register and its flag arithmetic
package asbs_pkg;

	typedef enum logic [3:0] {
		ASBS_OP_NONE,
		ASBS_OP_ADD,
		ASBS_OP_SUB,
		ASBS_OP_AND,
		ASBS_OP_IOR,
		ASBS_OP_XOR,
		ASBS_OP_MOVE_REG,
		ASBS_OP_ROT_LEFT,
		ASBS_OP_ROT_RIGHT,
		ASBS_OP_CLEAR,
		ASBS_OP_BIT_CLEAR,
		ASBS_OP_BIT_SET,
		ASBS_OP_SWAP,
		ASBS_OP_MOVE_ACC,
		ASBS_OP_WDT_CLEAR,
		ASBS_OP_SLEEP
	} asbs_op_type;

	typedef struct packed {
		logic        valid;
		asbs_op_type op;
		logic [7:0]  acc;
		logic [7:0]  operand;
		logic [2:0]  bit_sel;
		logic        to_reg;
		logic [6:0]  addr;
	} asbs_exec_type;

	typedef struct packed {
		logic       valid;
		logic       to_reg;
		logic [7:0] addr;
		logic [7:0] data;
	} asbs_wb_type;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} asbs_flags_type;

	typedef struct packed {
		logic indirect_bank_bit;
		logic direct_bank_high;
		logic direct_bank_low;
		logic timeout_flag_n;
		logic powerdown_flag_n;
		logic zero_flag;
		logic digit_carry_flag;
		logic carry_flag;
	} asbs_status_type;

endpackage

// >>> verilog/asbs_flag_alu.sv
// Result and flag arithmetic of one executed instruction
`timescale 1ns/1ps
`include "asbs_map.svh"
module asbs_flag_alu
	import asbs_pkg::*;
(
	// Instruction
	input  wire asbs_op_type    op,
	input  wire logic [7:0]     acc,
	input  wire logic [7:0]     operand,
	input  wire logic [2:0]     bit_sel,
	input  wire logic           carry_in,
	// Results
	output logic [7:0]          result,
	output asbs_flags_type      flags,
	output asbs_flags_type      touch
);
	logic       sub;
	logic [7:0] addend;
	logic [8:0] sum;
	logic [4:0] nib;

	// Subtract is operand plus inverted acc plus one, so carries read as active-low borrows
	always_comb begin
		sub    = (op == ASBS_OP_SUB);
		addend = sub ? ~acc : acc;
		sum    = {1'b0, operand} + {1'b0, addend} + {8'h00, sub};
		nib    = {1'b0, operand[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
	end

	always_comb begin
		result = operand;
		touch  = '0;
		flags  = '0;
		flags.c  = sum[8];
		flags.dc = nib[4];
		unique case (op)
			ASBS_OP_ADD, ASBS_OP_SUB: begin
				result = sum[7:0];
				touch  = 3'b111;
			end
			ASBS_OP_AND: begin
				result  = operand & acc;
				touch.z = 1'b1;
			end
			ASBS_OP_IOR: begin
				result  = operand | acc;
				touch.z = 1'b1;
			end
			ASBS_OP_XOR: begin
				result  = operand ^ acc;
				touch.z = 1'b1;
			end
			ASBS_OP_MOVE_REG: touch.z = 1'b1;
			ASBS_OP_ROT_LEFT: begin
				result  = {operand[6:0], carry_in};
				flags.c = operand[7];
				touch.c = 1'b1;
			end
			ASBS_OP_ROT_RIGHT: begin
				result  = {carry_in, operand[7:1]};
				flags.c = operand[0];
				touch.c = 1'b1;
			end
			ASBS_OP_CLEAR: begin
				result  = `ASBS_ZERO_BYTE;
				touch.z = 1'b1;
			end
			// Bit ops, swap and move-acc leave every flag alone
			ASBS_OP_BIT_CLEAR: result[bit_sel] = 1'b0;
			ASBS_OP_BIT_SET:   result[bit_sel] = 1'b1;
			ASBS_OP_SWAP:      result = {operand[3:0], operand[7:4]};
			ASBS_OP_MOVE_ACC:  result = acc;
			ASBS_OP_NONE, ASBS_OP_WDT_CLEAR, ASBS_OP_SLEEP: result = operand;
		endcase
		flags.z = (result == `ASBS_ZERO_BYTE);
	end
endmodule

// >>> verilog/asbs_status_reg.sv
// Arithmetic status, reset cause and bank select register with its writeback path
`timescale 1ns/1ps
`include "asbs_map.svh"
module asbs_status_reg
	import asbs_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// Instruction execution from the core
	input  wire asbs_exec_type   exec,
	// Watchdog time-out, raw level from the watchdog oscillator domain
	input  wire logic            watchdog_timeout,
	// Register state
	output asbs_status_type      status_q,
	// Registered writeback to data memory
	output asbs_wb_type          wb_q
);
	logic [2:0]     bank_q;
	logic           to_n_q;
	logic           pd_n_q;
	asbs_flags_type flags_q;
	logic           wdt_meta_q;
	logic           wdt_sync_q;
	logic           wdt_prev_q;
	logic           wdt_event;
	logic           hit;
	logic           wr_status;
	logic [7:0]     operand_eff;
	logic [7:0]     alu_result;
	asbs_flags_type alu_flags;
	asbs_flags_type alu_touch;
	logic [7:0]     eff_addr;

	// Whole reset word in one place so every field resets from the same constant
	localparam logic [7:0] status_reset = `ASBS_STATUS_RESET;

	assign status_q = {bank_q, to_n_q, pd_n_q, flags_q};

	// Status answers at its address in either bank
	assign hit         = exec.valid && (exec.addr == `ASBS_STATUS_ADDR);
	assign wr_status   = hit && exec.to_reg;
	assign operand_eff = hit ? status_q : exec.operand;
	// Direct addressing: bank 1 begins at 80h
	assign eff_addr    = bank_q[0] ? (`ASBS_BANK1_BASE | {1'b0, exec.addr}) : {1'b0, exec.addr};

	asbs_flag_alu u_alu (
		.op       (exec.op),
		.acc      (exec.acc),
		.operand  (operand_eff),
		.bit_sel  (exec.bit_sel),
		.carry_in (flags_q.c),
		.result   (alu_result),
		.flags    (alu_flags),
		.touch    (alu_touch)
	);

	// Time-out comes from another oscillator; edge is taken after the second flop
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wdt_meta_q <= 1'b0;
			wdt_sync_q <= 1'b0;
			wdt_prev_q <= 1'b0;
		end else begin
			wdt_meta_q <= watchdog_timeout;
			wdt_sync_q <= wdt_meta_q;
			wdt_prev_q <= wdt_sync_q;
		end
	end
	assign wdt_event = wdt_sync_q && !wdt_prev_q;

	// Bank bits are plain storage; the upper two drive nothing here
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bank_q <= status_reset[7:5];
		end else if (wr_status) begin
			bank_q <= alu_result[7:5];
		end
	end

	// Reset-cause bits take no data write at all; time-out wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			to_n_q <= status_reset[4];
			pd_n_q <= status_reset[3];
		end else if (wdt_event) begin
			to_n_q <= 1'b0;
		end else if (exec.valid && exec.op == ASBS_OP_WDT_CLEAR) begin
			to_n_q <= 1'b1;
			pd_n_q <= 1'b1;
		end else if (exec.valid && exec.op == ASBS_OP_SLEEP) begin
			to_n_q <= 1'b1;
			pd_n_q <= 1'b0;
		end
	end

	// A flag-touching instruction masks the data write to all three flags
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flags_q <= status_reset[2:0];
		end else if (exec.valid) begin
			if (wr_status && alu_touch == '0) begin
				flags_q <= alu_result[2:0];
			end else begin
				if (alu_touch.z) begin
					flags_q.z <= alu_flags.z;
				end
				if (alu_touch.dc) begin
					flags_q.dc <= alu_flags.dc;
				end
				if (alu_touch.c) begin
					flags_q.c <= alu_flags.c;
				end
			end
		end
	end

	// Writeback to the data memory for every valid instruction but a no-op, register destination or not
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wb_q <= '0;
		end else begin
			wb_q.valid  <= exec.valid && exec.op != ASBS_OP_NONE;
			wb_q.to_reg <= exec.to_reg;
			wb_q.addr   <= eff_addr;
			wb_q.data   <= alu_result;
		end
	end

	// Helper terms read only by the checks below
	logic [4:0] chk_nib_add;
	logic       chk_no_borrow;
	logic       chk_flag_op;
	assign chk_nib_add   = {1'b0, operand_eff[3:0]} + {1'b0, exec.acc[3:0]};
	assign chk_no_borrow = operand_eff >= exec.acc;
	assign chk_flag_op   = exec.op inside {ASBS_OP_ADD, ASBS_OP_SUB, ASBS_OP_AND, ASBS_OP_IOR,
	                                       ASBS_OP_XOR, ASBS_OP_MOVE_REG, ASBS_OP_CLEAR};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_status_dest;
		exec.valid && exec.to_reg && exec.op == ASBS_OP_MOVE_ACC |=>
			wb_q.valid && wb_q.data == $past(exec.acc);
	endproperty
	a_status_dest: assert property (p_status_dest) else $error("register writeback missing");

	property p_flag_write_blocked;
		wr_status && exec.op == ASBS_OP_ADD |=> flags_q == $past(alu_flags);
	endproperty
	a_flag_write_blocked: assert property (p_flag_write_blocked) else $error("flags took written data");

	property p_flag_from_logic;
		wr_status && exec.op == ASBS_OP_SUB |=> flags_q.c == $past(chk_no_borrow);
	endproperty
	a_flag_from_logic: assert property (p_flag_from_logic) else $error("flags not from instruction logic");

	property p_reset_cause_ro;
		wr_status && exec.op == ASBS_OP_MOVE_ACC && !wdt_event |=>
			to_n_q == $past(to_n_q) && pd_n_q == $past(pd_n_q);
	endproperty
	a_reset_cause_ro: assert property (p_reset_cause_ro) else $error("reset cause bit was written");

	property p_clear_status;
		wr_status && exec.op == ASBS_OP_CLEAR |=>
			bank_q == 3'b000 && flags_q.z && flags_q.dc == $past(flags_q.dc) && flags_q.c == $past(flags_q.c);
	endproperty
	a_clear_status: assert property (p_clear_status) else $error("clear of status wrong");

	property p_safe_write;
		wr_status && exec.op == ASBS_OP_MOVE_ACC |=>
			{bank_q, flags_q} == {$past(exec.acc[7:5]), $past(exec.acc[2:0])};
	endproperty
	a_safe_write: assert property (p_safe_write) else $error("safe write did not land");

	property p_upper_hold;
		!wr_status |=> bank_q == $past(bank_q);
	endproperty
	a_upper_hold: assert property (p_upper_hold) else $error("bank bits moved without write");

	property p_bank_addr;
		exec.valid |=> wb_q.addr[7] == $past(bank_q[0]) && wb_q.addr[6:0] == $past(exec.addr);
	endproperty
	a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");

	property p_digit_carry;
		exec.valid && !hit && exec.op == ASBS_OP_ADD |=> flags_q.dc == ($past(chk_nib_add) > `ASBS_NIBBLE_MAX);
	endproperty
	a_digit_carry: assert property (p_digit_carry) else $error("digit carry wrong");

	property p_borrow;
		exec.valid && !hit && exec.op == ASBS_OP_SUB |=> flags_q.c == $past(chk_no_borrow);
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

	property p_timeout;
		$rose(wdt_sync_q) |=> !to_n_q;
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out not recorded");

	property p_sleep;
		exec.valid && exec.op == ASBS_OP_SLEEP && !wdt_event |=> to_n_q && !pd_n_q;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

	property p_zero;
		exec.valid && !hit && chk_flag_op |=> flags_q.z == ($past(alu_result) == `ASBS_ZERO_BYTE);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	c_add_to_status: cover property (wr_status && exec.op == ASBS_OP_ADD);
	c_clear_status:  cover property (wr_status && exec.op == ASBS_OP_CLEAR);
	c_timeout:       cover property (wdt_event ##1 exec.valid && exec.op == ASBS_OP_WDT_CLEAR);
	c_bank_switch:   cover property (!bank_q[0] ##1 bank_q[0]);
endmodule

// >>> verification/asbs_core_model.sv
// Behavioural core model that presents executed instructions to the status register
`timescale 1ns/1ps
module asbs_core_model
	import asbs_pkg::*;
(
	// Clock
	input  wire logic     clk,
	// Instruction stream
	output asbs_exec_type exec
);
	initial exec = '0;

	// One instruction per edge, launched on the edge so that back-to-back issue is possible
	task automatic send(input asbs_op_type op, input logic [7:0] a, f, input logic [2:0] b, input logic t,
		input logic [6:0] ad);
		@(posedge clk);
		exec <= '{1'b1, op, a, f, b, t, ad};
	endtask

	task automatic idle();
		@(posedge clk);
		exec <= '0;
	endtask
endmodule

// >>> verification/alu_status_bank_select_reg_bench.sv
// Self-checking bench for the status and bank select register
`timescale 1ns/1ps
module alu_status_bank_select_reg_bench;
	import asbs_pkg::*;
	logic            clk;
	logic            reset_n;
	logic            watchdog_timeout;
	asbs_exec_type   exec;
	asbs_status_type status_q;
	asbs_wb_type     wb_q;
	logic [7:0]      st;
	logic [24:0]     expq[$];
	int              bad_count = 0;
	int              compares = 0;
	int              cycles = 0;

	asbs_core_model core (.clk(clk), .exec(exec));
	asbs_status_reg DUT (.clk(clk), .reset_n(reset_n), .exec(exec), .watchdog_timeout(watchdog_timeout),
		.status_q(status_q), .wb_q(wb_q));

	initial clk = 1'b0;
	always #2 clk = ~clk;

	task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
		compares++;
		if (got !== want) begin
			bad_count++;
			$display("BAD %0t %s got %h want %h", $time, what, got, want);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Reference model: works out the next status and result before the instruction is sent
	task automatic issue(input asbs_op_type op, input logic [7:0] a, f, input logic [2:0] b, input logic [6:0] ad);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		logic [7:0] n;
		logic [2:0] fl;
		logic       t;
		t = (ad == 7'h03);
		if (t && op == ASBS_OP_MOVE_ACC) a[7:6] = 2'b00;
		if (t) f = st;
		n = st;
		fl = st[2:0];
		r = f;
		case (op)
			ASBS_OP_ADD: begin
				s = {1'b0, a} + {1'b0, f};
				h = {1'b0, a[3:0]} + {1'b0, f[3:0]};
				r = s[7:0];
				fl = {r == 8'h00, h[4], s[8]};
			end
			ASBS_OP_SUB: begin
				s = {1'b0, f} - {1'b0, a};
				h = {1'b0, f[3:0]} - {1'b0, a[3:0]};
				r = s[7:0];
				fl = {r == 8'h00, ~h[4], ~s[8]};
			end
			ASBS_OP_AND: r = f & a;
			ASBS_OP_IOR: r = f | a;
			ASBS_OP_XOR: r = f ^ a;
			ASBS_OP_ROT_LEFT: begin
				r = {f[6:0], st[0]};
				fl[0] = f[7];
			end
			ASBS_OP_ROT_RIGHT: begin
				r = {st[0], f[7:1]};
				fl[0] = f[0];
			end
			ASBS_OP_CLEAR: r = 8'h00;
			ASBS_OP_BIT_SET: r[b] = 1'b1;
			ASBS_OP_BIT_CLEAR: r[b] = 1'b0;
			ASBS_OP_SWAP: r = {f[3:0], f[7:4]};
			ASBS_OP_MOVE_ACC: r = a;
			ASBS_OP_WDT_CLEAR: n[4:3] = 2'b11;
			ASBS_OP_SLEEP: n[4:3] = 2'b10;
			default: ;
		endcase
		if (op inside {ASBS_OP_AND, ASBS_OP_IOR, ASBS_OP_XOR, ASBS_OP_MOVE_REG, ASBS_OP_CLEAR})
			fl[2] = (r == 8'h00);
		if (t) n = {r[7:5], n[4:3], r[2:0]};
		if (op inside {ASBS_OP_ADD, ASBS_OP_SUB, ASBS_OP_AND, ASBS_OP_IOR, ASBS_OP_XOR, ASBS_OP_MOVE_REG,
			ASBS_OP_ROT_LEFT, ASBS_OP_ROT_RIGHT, ASBS_OP_CLEAR}) n[2:0] = fl;
		expq.push_back({!(op inside {ASBS_OP_WDT_CLEAR, ASBS_OP_SLEEP}), n, r, st[5], ad});
		st = n;
		core.send(op, a, f, b, t, ad);
	endtask

	task automatic fin(input string name);
		core.idle();
		repeat (3) @(posedge clk);
		if (expq.size() != 0) begin
			bad_count++;
			$display("BAD %0t %s writebacks missing", $time, name);
		end
		$display("test %s finished", name);
	endtask

	// Monitor: each writeback pulse consumes the oldest expectation
	always @(negedge clk) begin
		logic [24:0] e;
		if (reset_n === 1'b1 && wb_q.valid === 1'b1) begin
			if (expq.size() == 0) begin
				bad_count++;
				$display("BAD %0t unexpected writeback", $time);
			end else begin
				e = expq.pop_front();
				check(status_q, e[23:16], "status");
				check(wb_q.addr, e[7:0], "address");
				check(wb_q.to_reg, e[6:0] == 7'h03, "target");
				if (e[24]) check(wb_q.data, e[15:8], "result");
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			$display("BAD %0t run did not finish", $time);
			stop_test();
		end
	end

	initial begin
		reset_n = 1'b0;
		watchdog_timeout = 1'b0;
		st = 8'h18;
		void'($urandom(32'h0041));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		check(status_q, 8'h18, "reset value");
		issue(ASBS_OP_MOVE_ACC, 8'hFF, 8'h00, 3'h0, 7'h03);
		for (int i = 0; i < 6; i++) issue(ASBS_OP_BIT_CLEAR, 8'h00, 8'h00, i[2:0], 7'h03);
		for (int i = 0; i < 6; i++) issue(ASBS_OP_BIT_SET, 8'h00, 8'h00, i[2:0], 7'h03);
		fin("safe writes");
		issue(ASBS_OP_MOVE_ACC, 8'h07, 8'h00, 3'h0, 7'h03);
		issue(ASBS_OP_CLEAR, 8'h00, 8'h00, 3'h0, 7'h03);
		issue(ASBS_OP_ADD, 8'h0F, 8'h00, 3'h0, 7'h03);
		issue(ASBS_OP_SUB, 8'h1A, 8'h00, 3'h0, 7'h03);
		fin("flag ops on status");
		issue(ASBS_OP_ADD, 8'h0F, 8'h01, 3'h0, 7'h20);
		issue(ASBS_OP_ADD, 8'hFF, 8'h01, 3'h0, 7'h20);
		issue(ASBS_OP_SUB, 8'h5A, 8'h5A, 3'h0, 7'h20);
		issue(ASBS_OP_SUB, 8'h01, 8'h00, 3'h0, 7'h20);
		for (int i = 0; i < 16; i++) issue(i[0] ? ASBS_OP_SUB : ASBS_OP_ADD, 8'($urandom), 8'($urandom), 3'h0, 7'h20);
		issue(ASBS_OP_AND, 8'hF0, 8'h0F, 3'h0, 7'h20);
		issue(ASBS_OP_XOR, 8'h5A, 8'h5A, 3'h0, 7'h20);
		issue(ASBS_OP_ROT_LEFT, 8'h00, 8'h80, 3'h0, 7'h20);
		issue(ASBS_OP_ROT_RIGHT, 8'h00, 8'h01, 3'h0, 7'h20);
		for (int i = 0; i < 12; i++)
			issue(asbs_op_type'(4'(3 + i % 6)), 8'($urandom), 8'($urandom), 3'h0, 7'h20);
		fin("arithmetic flags");
		issue(ASBS_OP_BIT_SET, 8'h00, 8'h00, 3'h5, 7'h03);
		issue(ASBS_OP_ADD, 8'($urandom), 8'($urandom), 3'h0, 7'h20);
		issue(ASBS_OP_BIT_CLEAR, 8'h00, 8'h00, 3'h5, 7'h03);
		issue(ASBS_OP_SLEEP, 8'h00, 8'h00, 3'h0, 7'h20);
		// Swap only once the power-down and zero bits are low, so bits 7:6 stay clear
		issue(ASBS_OP_BIT_CLEAR, 8'h00, 8'h00, 3'h2, 7'h03);
		issue(ASBS_OP_SWAP, 8'h00, 8'h00, 3'h0, 7'h03);
		issue(ASBS_OP_WDT_CLEAR, 8'h00, 8'h00, 3'h0, 7'h20);
		fin("bank and power events");
		// The time-out crosses a two-flop synchroniser, so it lands on the third edge
		@(posedge clk);
		watchdog_timeout <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(status_q, st, "timeout too early");
		@(negedge clk);
		st[4] = 1'b0;
		check(status_q, st, "timeout flag");
		@(posedge clk);
		watchdog_timeout <= 1'b0;
		issue(ASBS_OP_MOVE_ACC, 8'h18, 8'h00, 3'h0, 7'h03);
		issue(ASBS_OP_WDT_CLEAR, 8'h00, 8'h00, 3'h0, 7'h20);
		fin("watchdog timeout");
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		check(status_q, 8'h18, "second reset");
		st = 8'h18;
		issue(ASBS_OP_MOVE_ACC, 8'h20, 8'h00, 3'h0, 7'h03);
		fin("second reset");
		stop_test();
	end
endmodule
